/* File: pkg/ufc_defs.svh */
// constants of the unsigned float convert unit: flag bits, field places, offsets, timing
`ifndef UFC_DEFS_SVH
`define UFC_DEFS_SVH

// exception flag vector, same layout in status word and probe results
`define UFC_FLAG_W          6
`define UFC_FLAG_INEXACT    6'h02
`define UFC_FLAG_INVALID    6'h10
`define UFC_FLAG_FLUSHED    6'h20
`define UFC_FLAG_MASK       6'h3F

// status word fields
`define UFC_PSW_FLAG_LSB    0
`define UFC_PSW_RMODE_LSB   8
`define UFC_PSW_RESET       32'h0000_0000

// register port offsets
`define UFC_ADDR_PSW        4'h0
`define UFC_ADDR_IRQ_STAT   4'h4
`define UFC_ADDR_IRQ_MASK   4'h8
`define UFC_ADDR_PIPE_STAT  4'hC

// interrupt event bits
`define UFC_IRQ_W           2
`define UFC_IRQ_BAD_SLOT    2'h1
`define UFC_IRQ_EXCEPTION   2'h2

// result latency in cycles and legal issue slots
`define UFC_LATENCY         3
`define UFC_SLOT_A          3'h1
`define UFC_SLOT_B          3'h4

// float constants
`define UFC_WORD_ALL_ONES   32'hFFFF_FFFF
`define UFC_EXP_BIAS        8'h7F
`define UFC_EXP_MAX         8'hFF
`define UFC_EXP_U32_LIMIT   8'h9F

`endif

/* File: pkg/ufc_pkg.sv */
// types of the unsigned float convert unit
package ufc_pkg;

    // the four operations handled by this unit
    typedef enum logic [1:0]
    {
        UFC_OP_FIX_TRUNC,
        UFC_OP_FIX_TRUNC_FLAGS,
        UFC_OP_UFLOAT,
        UFC_OP_UFLOAT_FLAGS
    } ufc_op_t;

    // rounding modes held in the status word
    typedef enum logic [1:0]
    {
        UFC_RM_NEAREST,
        UFC_RM_POS_INF,
        UFC_RM_NEG_INF,
        UFC_RM_ZERO
    } ufc_rmode_t;

endpackage : ufc_pkg

/* File: testbench/test_unsigned_float_convert_unit.sv */
// self-checking bench of the unsigned float convert unit
`include "ufc_defs.svh"

module test_unsigned_float_convert_unit;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk = 1'b0;       // core clock
    logic        rst = 1'b1;       // synchronous reset
    logic        iv = 1'b0;        // issue valid
    logic [2:0]  sl = 3'h1;        // issue slot
    logic [1:0]  opc = 2'h0;       // opcode
    logic [31:0] src = 32'h0000_0000; // source operand
    logic        gp = 1'b0;        // guard present
    logic [31:0] grd = 32'h0000_0000; // guard value
    logic [6:0]  dst = 7'h00;      // destination index
    logic [5:0]  oth = 6'h00;      // flags of other units
    logic [3:0]  ra = 4'h0;        // register address
    logic [31:0] rwd = 32'h0000_0000; // register write data
    logic        rwr = 1'b0;       // register write strobe
    logic        rrd = 1'b0;       // register read strobe
    logic [31:0] rdata, wbdat, psw; // design outputs
    logic        rej, wbv, irq;    // design outputs
    logic [6:0]  wbd;              // written index
    logic [31:0] res, pre, rv;     // sampled result, status before write, read value
    logic        hit, rj;          // write seen, reject seen
    int          failures = 0;
    int          total_checks = 0;
    // truncating probe table; the negative fraction proves no rounding-mode effect
    logic [31:0] fs [8] = '{32'h4040_0000, 32'h4024_7AE1, 32'hFF4F_FFFF, 32'h7F80_0000,
                            32'hBFC1_47AE, 32'h0040_0000, 32'hFFBF_FFFF, 32'hBF00_0000};
    logic [5:0]  ff [8] = '{6'h00, 6'h02, 6'h10, 6'h10, 6'h10, 6'h20, 6'h10, 6'h02};

    // free-running core clock, 10 ns period
    initial
    begin
        forever #5 clk = ~clk;
    end

    ufc_convert_unit i_dut
    (
        .I_CLK_SYS(clk), .I_RST(rst), .I_CE(1'b1), .I_ISSUE_VALID(iv), .I_ISSUE_SLOT(sl),
        .I_OPCODE(opc), .I_SOURCE_OPERAND(src), .I_GUARD_PRESENT(gp), .I_GUARD(grd),
        .I_DEST(dst), .I_OTHER_FLAGS(oth), .I_REG_ADDR(ra), .I_REG_WDATA(rwd),
        .I_REG_WR(rwr), .I_REG_RD(rrd), .O_REG_RDATA(rdata), .O_ISSUE_REJECT(rej),
        .O_WB_VALID(wbv), .O_WB_DEST(wbd), .O_WB_DATA(wbdat),
        .O_PROCESSOR_STATUS_WORD(psw), .O_IRQ(irq)
    );

    ufc_core_model i_core (.i_clk(clk), .i_wb_valid(wbv), .i_wb_dest(wbd), .i_wb_data(wbdat));

    // one compare kind: 32-bit case equality
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        ra <= a; rwd <= d; rwr <= 1'b1;
        @(posedge clk);
        rwr <= 1'b0;
        // let the write settle before anyone looks at the registers
        #1;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic reg_rd(input logic [3:0] a);
        @(posedge clk);
        ra <= a; rrd <= 1'b1;
        @(posedge clk);
        rrd <= 1'b0;
        #1 rv = rdata;
    endtask

    // one op: issue, check nothing lands early, sample in the write-back cycle
    task automatic op_run(input logic [1:0] op, input logic [31:0] s, input logic p, input logic [31:0] g);
        @(posedge clk);
        iv <= 1'b1; opc <= op; src <= s; gp <= p; grd <= g; dst <= dst + 7'h01;
        #1 rj = rej;
        @(posedge clk);
        iv <= 1'b0;
        @(posedge clk);
        #1 pre = psw;
        chk({31'h0, wbv}, 32'h0000_0000);
        @(posedge clk);
        #1 hit = wbv;
        res = wbdat;
        if (hit === 1'b1)
            chk({25'h0, wbd}, {25'h0, dst});
    endtask

    // probe: vector in low bits, status word untouched
    task automatic probe(input logic [1:0] op, input logic [31:0] s, input logic [5:0] f);
        op_run(op, s, 1'b0, 32'h0000_0000);
        chk({31'h0, hit}, 32'h0000_0001);
        chk(res, {26'h0, f});
        chk(psw, pre);
    endtask

    // conversion from cleared flags: result, flags only with the write
    task automatic conv(input logic [1:0] op, input logic [1:0] rm, input logic [31:0] s,
                        input logic [31:0] e, input logic [5:0] f);
        reg_wr(`UFC_ADDR_PSW, {22'h0, rm, 8'h00});
        op_run(op, s, 1'b1, 32'h0000_0001);
        chk(res, e);
        chk(pre, {22'h0, rm, 8'h00});
        chk(psw, {22'h0, rm, 2'h0, f});
    endtask

    task automatic t_reset();
        chk(psw, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0000);
        reg_rd(`UFC_ADDR_PIPE_STAT);
        chk(rv, 32'h0000_0000);
        reg_rd(4'h2); // unmapped
        chk(rv, 32'h0000_0000);
        $display("test reset done");
    endtask

    // rounding mode toward minus infinity must not change truncation
    task automatic t_trunc();
        reg_wr(`UFC_ADDR_PSW, 32'h0000_0200);
        foreach (fs[i])
            probe(ufc_pkg::UFC_OP_FIX_TRUNC_FLAGS, fs[i], ff[i]);
        conv(ufc_pkg::UFC_OP_FIX_TRUNC, 2'h1, 32'h4024_7AE1, 32'h0000_0002, 6'h02);
        conv(ufc_pkg::UFC_OP_FIX_TRUNC, 2'h0, 32'h0040_0000, 32'h0000_0000, 6'h20);
        conv(ufc_pkg::UFC_OP_FIX_TRUNC, 2'h0, 32'h7F80_0000, 32'hFFFF_FFFF, 6'h10);
        $display("test truncation done");
    endtask

    task automatic t_ufloat();
        conv(ufc_pkg::UFC_OP_UFLOAT, 2'h0, 32'hFFFF_FFFF, 32'h4F80_0000, 6'h02);
        conv(ufc_pkg::UFC_OP_UFLOAT, 2'h3, 32'hFFFF_FFFF, 32'h4F7F_FFFF, 6'h02);
        conv(ufc_pkg::UFC_OP_UFLOAT, 2'h0, 32'h7FFF_FFFF, 32'h4F00_0000, 6'h02);
        conv(ufc_pkg::UFC_OP_UFLOAT, 2'h0, 32'h8000_0000, 32'h4F00_0000, 6'h00);
        conv(ufc_pkg::UFC_OP_UFLOAT, 2'h0, 32'h0000_0003, 32'h4040_0000, 6'h00);
        conv(ufc_pkg::UFC_OP_UFLOAT, 2'h1, 32'h7FFF_FFF1, 32'h4F00_0000, 6'h02);
        conv(ufc_pkg::UFC_OP_UFLOAT, 2'h2, 32'h7FFF_FFF1, 32'h4EFF_FFFF, 6'h02);
        probe(ufc_pkg::UFC_OP_UFLOAT_FLAGS, 32'hFFFF_FFFD, 6'h02);
        probe(ufc_pkg::UFC_OP_UFLOAT_FLAGS, 32'h8000_0000, 6'h00);
        $display("test unsigned to float done");
    endtask

    // guard bit zero (upper bits set) blocks write and flags; absent guard always writes
    task automatic t_guard();
        reg_wr(`UFC_ADDR_PSW, 32'h0000_0000);
        op_run(ufc_pkg::UFC_OP_UFLOAT, 32'hFFFF_FFFF, 1'b1, 32'hFFFF_FFFE);
        chk({31'h0, hit}, 32'h0000_0000);
        chk(psw, 32'h0000_0000);
        @(posedge clk);
        #1;
        chk(i_core.regs[dst], 32'hA5A5_A5A5);
        op_run(ufc_pkg::UFC_OP_FIX_TRUNC_FLAGS, 32'h7F80_0000, 1'b1, 32'h0000_0000);
        chk({31'h0, hit}, 32'h0000_0000);
        op_run(ufc_pkg::UFC_OP_UFLOAT, 32'h0000_0003, 1'b0, 32'h0000_0000);
        // the register file takes the value at the edge closing the write cycle
        @(posedge clk);
        #1;
        chk(i_core.regs[dst], 32'h4040_0000);
        $display("test guard done");
    endtask

    // flags stay through exact ops, OR with other units, clear only by status write
    task automatic t_sticky();
        conv(ufc_pkg::UFC_OP_UFLOAT, 2'h0, 32'hFFFF_FFFF, 32'h4F80_0000, 6'h02);
        @(posedge clk) oth <= 6'h01;
        op_run(ufc_pkg::UFC_OP_UFLOAT, 32'h7FFF_FFFF, 1'b1, 32'h0000_0001);
        @(posedge clk) oth <= 6'h00;
        chk(psw, 32'h0000_0003);
        op_run(ufc_pkg::UFC_OP_UFLOAT, 32'h0000_0003, 1'b1, 32'h0000_0001);
        chk(psw, 32'h0000_0003);
        reg_wr(`UFC_ADDR_PSW, 32'h0000_0000);
        chk(psw, 32'h0000_0000);
        $display("test sticky done");
    endtask

    // wrong slot refused and raises the masked interrupt; slot four accepted
    task automatic t_slot();
        reg_wr(`UFC_ADDR_IRQ_STAT, 32'h0000_0003);
        reg_wr(`UFC_ADDR_IRQ_MASK, 32'h0000_0001);
        @(posedge clk) sl <= 3'h2;
        op_run(ufc_pkg::UFC_OP_UFLOAT, 32'h0000_0003, 1'b0, 32'h0000_0000);
        chk({30'h0, rj, hit}, 32'h0000_0002);
        chk({31'h0, irq}, 32'h0000_0001);
        reg_rd(`UFC_ADDR_IRQ_STAT);
        chk(rv & 32'h0000_0001, 32'h0000_0001);
        reg_wr(`UFC_ADDR_IRQ_STAT, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0000_0000);
        @(posedge clk) sl <= 3'h4;
        op_run(ufc_pkg::UFC_OP_UFLOAT, 32'h0000_0003, 1'b0, 32'h0000_0000);
        chk({30'h0, rj, hit}, 32'h0000_0001);
        $display("test slots done");
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // main sequence after six reset cycles
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_trunc();
        t_ufloat();
        t_guard();
        t_sticky();
        t_slot();
        stop_test();
    end

    // watchdog: the run needs well under a thousand cycles
    initial
    begin
        #100000;
        failures++;
        stop_test();
    end
endmodule // test_unsigned_float_convert_unit

/* File: testbench/ufc_core_model.sv */
// core side register file model: keeps what the unit writes back
module ufc_core_model
(
    input  wire logic        i_clk,      // core clock
    input  wire logic        i_wb_valid, // destination write this cycle
    input  wire logic [6:0]  i_wb_dest,  // destination index
    input  wire logic [31:0] i_wb_data   // destination value
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [31:0] regs [128]; // register file

    // marker fill, so an entry that must stay untouched shows any stray write
    initial
    begin
        foreach (regs[i])
            regs[i] = 32'hA5A5_A5A5;
    end

    // only a flagged write cycle changes an entry
    always @(posedge i_clk)
    begin
        if (i_wb_valid === 1'b1)
            regs[i_wb_dest] <= i_wb_data;
    end
endmodule // ufc_core_model

/* File: verilog/ufc_convert_unit.sv */
// unsigned float convert unit: float to unsigned truncation, unsigned to float, flag probes
`include "ufc_defs.svh"

// Overview of operation
// - truncating probe writes would-be exceptions
// - probe vector uses status word flag layout
// - probes never touch status word flags
// - truncating probe always rounds toward zero
// - denormal source flushed, flushed bit set
// - guard bit zero blocks destination write
// - unsigned to float writes single result
// - unsigned conversion rounds by status mode
// - conversion exceptions set status word flags
// - flags sticky, cleared only by status write
// - flags update with destination write
// - concurrent updates or into each flag
// - false guard writes neither dest nor flags
// - unsigned probe writes would-be exceptions
// - truncating conversion flushes denormals into flags
module ufc_convert_unit
(
    input  wire logic        I_CLK_SYS,          // core clock
    input  wire logic        I_RST,              // synchronous reset
    input  wire logic        I_CE,               // clock enable, freezes all state
    input  wire logic        I_ISSUE_VALID,      // operation issued this cycle
    input  wire logic [2:0]  I_ISSUE_SLOT,       // issue slot number
    input  wire logic [1:0]  I_OPCODE,           // operation select
    input  wire logic [31:0] I_SOURCE_OPERAND,   // single source operand
    input  wire logic        I_GUARD_PRESENT,    // a guard register is given
    input  wire logic [31:0] I_GUARD,            // guard register value
    input  wire logic [6:0]  I_DEST,             // destination register index
    input  wire logic [5:0]  I_OTHER_FLAGS,      // flags from other fp units this cycle
    input  wire logic [3:0]  I_REG_ADDR,         // register port address
    input  wire logic [31:0] I_REG_WDATA,        // register port write data
    input  wire logic        I_REG_WR,           // register write strobe
    input  wire logic        I_REG_RD,           // register read strobe
    output logic      [31:0] O_REG_RDATA,        // read data, cycle after strobe
    output logic             O_ISSUE_REJECT,     // issue refused, wrong slot
    output logic             O_WB_VALID,         // destination write this cycle
    output logic      [6:0]  O_WB_DEST,          // destination register index
    output logic      [31:0] O_WB_DATA,          // destination value
    output logic      [31:0] O_PROCESSOR_STATUS_WORD, // current status word
    output logic             O_IRQ               // unmasked interrupt pending
);

    // stage record kept in flops at each pipeline step
    logic                   s1_valid, s2_valid;  // write pending at stage
    logic                   s1_probe, s2_probe;  // result is a flag vector
    logic [6:0]             s1_dest,  s2_dest;
    logic [31:0]            s1_data,  s2_data;
    logic [`UFC_FLAG_W-1:0] s1_flags, s2_flags;  // flags raised by the operation

    logic [`UFC_FLAG_W-1:0] psw_flags;           // sticky exception flags
    ufc_pkg::ufc_rmode_t    psw_rmode;           // rounding mode
    logic [`UFC_IRQ_W-1:0]  irq_status;          // sticky events
    logic [`UFC_IRQ_W-1:0]  irq_mask;            // event enables

    // float to unsigned with truncation; returns {flags, value}
    function automatic logic [37:0] fix_trunc(input logic [31:0] f);
        logic [7:0]  e;
        logic [55:0] prod;
        logic [31:0] val;
        logic [5:0]  fl;
        e    = f[30:23];
        prod = 56'h00_0000_0000_0000;
        val  = 32'h0000_0000;
        fl   = '0;
        if (e == 8'h00)
        begin
            // denormal is flushed to zero, zero itself raises nothing
            if (f[22:0] != 23'h00_0000)
            begin
                fl = `UFC_FLAG_FLUSHED;
            end
        end
        else if (e == `UFC_EXP_MAX)
        begin
            fl = `UFC_FLAG_INVALID;
            if (!f[31] && f[22:0] == 23'h00_0000)
            begin
                val = `UFC_WORD_ALL_ONES;           // plus infinity saturates
            end
        end
        else if (e < `UFC_EXP_BIAS)
        begin
            fl = `UFC_FLAG_INEXACT;                     // magnitude below one
        end
        else if (f[31])
        begin
            fl = `UFC_FLAG_INVALID;                     // negative, one or more
        end
        else if (e >= `UFC_EXP_U32_LIMIT)
        begin
            fl  = `UFC_FLAG_INVALID;
            val = `UFC_WORD_ALL_ONES;
        end
        else
        begin
            // round toward zero: drop the fraction, never add
            prod = {32'h0000_0000, 1'b1, f[22:0]} << 5'(e - `UFC_EXP_BIAS);
            val  = prod[54:23];
            fl   = (|prod[22:0]) ? `UFC_FLAG_INEXACT : '0;
        end
        return {fl, val};
    endfunction

    // issue decode
    logic        slot_ok;     // slot one or four
    logic        accept;      // operation taken into the pipe
    logic        guard_true;  // guard absent or lsb set
    ufc_pkg::ufc_op_t issue_op;
    logic [37:0] fix_res;     // truncation result and flags
    logic [31:0] flt_res;     // unsigned to float result
    logic [5:0]  flt_flags;   // unsigned to float flags
    logic [31:0] next_data;   // value to carry into stage one
    logic [5:0]  next_flags;  // flags to carry into stage one

    always_comb
    begin
        issue_op       = ufc_pkg::ufc_op_t'(I_OPCODE);
        slot_ok        = (I_ISSUE_SLOT == `UFC_SLOT_A) || (I_ISSUE_SLOT == `UFC_SLOT_B);
        accept         = I_ISSUE_VALID && slot_ok;
        O_ISSUE_REJECT = I_ISSUE_VALID && !slot_ok;
        guard_true     = !I_GUARD_PRESENT || I_GUARD[0];
        fix_res        = fix_trunc(I_SOURCE_OPERAND);
    end

    // unsigned to float converter, rounding from the live status word
    ufc_u2f_round u_u2f
    (
        .i_value  (I_SOURCE_OPERAND),
        .i_rmode  (psw_rmode),
        .o_result (flt_res),
        .o_flags  (flt_flags)
    );

    // select the destination value per operation
    always_comb
    begin
        case (issue_op)
            ufc_pkg::UFC_OP_FIX_TRUNC:
            begin
                next_data  = fix_res[31:0];
                next_flags = fix_res[37:32];
            end
            ufc_pkg::UFC_OP_FIX_TRUNC_FLAGS:
            begin
                next_data  = {26'h000_0000, fix_res[37:32]};
                next_flags = fix_res[37:32];
            end
            ufc_pkg::UFC_OP_UFLOAT:
            begin
                next_data  = flt_res;
                next_flags = flt_flags;
            end
            default:
            begin
                next_data  = {26'h000_0000, flt_flags};
                next_flags = flt_flags;
            end
        endcase
    end

    // stage one: a false guard never enters, so it can write nothing later
    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_RST)
        begin
            s1_valid <= 1'b0;
            s1_probe <= 1'b0;
            s1_dest  <= 7'h00;
            s1_data  <= 32'h0000_0000;
            s1_flags <= '0;
        end
        else if (I_CE)
        begin
            s1_valid <= accept && guard_true;
            s1_probe <= (issue_op == ufc_pkg::UFC_OP_FIX_TRUNC_FLAGS) ||
                        (issue_op == ufc_pkg::UFC_OP_UFLOAT_FLAGS);
            s1_dest  <= I_DEST;
            s1_data  <= next_data;
            s1_flags <= next_flags;
        end
    end

    // stage two and the write-back register, after stage one, make up the three cycles
    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_RST)
        begin
            s2_valid   <= 1'b0;
            s2_probe   <= 1'b0;
            s2_dest    <= 7'h00;
            s2_data    <= 32'h0000_0000;
            s2_flags   <= '0;
            O_WB_VALID <= 1'b0;
            O_WB_DEST  <= 7'h00;
            O_WB_DATA  <= 32'h0000_0000;
        end
        else if (I_CE)
        begin
            s2_valid   <= s1_valid;
            s2_probe   <= s1_probe;
            s2_dest    <= s1_dest;
            s2_data    <= s1_data;
            s2_flags   <= s1_flags;
            O_WB_VALID <= s2_valid;
            O_WB_DEST  <= s2_dest;
            O_WB_DATA  <= s2_data;
        end
    end

    // flag contribution of this unit, loaded on the same edge as write-back
    logic [5:0] own_update;  // flags set by a real conversion
    logic       psw_write;   // software writes the status word
    assign own_update = (s2_valid && !s2_probe) ? s2_flags : '0;
    assign psw_write  = I_REG_WR && (I_REG_ADDR == `UFC_ADDR_PSW);

    // status word: a write loads flags from the write data, but an update in the same cycle still lands
    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_RST)
        begin
            psw_flags <= 6'(`UFC_PSW_RESET);
            psw_rmode <= ufc_pkg::UFC_RM_NEAREST;
        end
        else if (I_CE)
        begin
            if (psw_write)
            begin
                psw_flags <= I_REG_WDATA[5:0] | own_update | I_OTHER_FLAGS;
                psw_rmode <= ufc_pkg::ufc_rmode_t'(I_REG_WDATA[`UFC_PSW_RMODE_LSB +: 2]);
            end
            else
            begin
                psw_flags <= psw_flags | own_update | I_OTHER_FLAGS;
            end
        end
    end

    assign O_PROCESSOR_STATUS_WORD = {22'h00_0000, psw_rmode, 2'h0, psw_flags};

    // interrupt events: refused issue, or a conversion raising any flag
    logic [1:0] irq_event;
    assign irq_event = (O_ISSUE_REJECT ? `UFC_IRQ_BAD_SLOT : 2'h0) |
                       ((own_update != '0) ? `UFC_IRQ_EXCEPTION : 2'h0);

    // sticky status, write one to clear, an event in the same cycle wins
    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_RST)
        begin
            irq_status <= 2'h0;
        end
        else if (I_CE)
        begin
            if (I_REG_WR && I_REG_ADDR == `UFC_ADDR_IRQ_STAT)
            begin
                irq_status <= (irq_status & ~I_REG_WDATA[1:0]) | irq_event;
            end
            else
            begin
                irq_status <= irq_status | irq_event;
            end
        end
    end

    // interrupt mask
    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_RST)
        begin
            irq_mask <= 2'h0;
        end
        else if (I_CE && I_REG_WR && I_REG_ADDR == `UFC_ADDR_IRQ_MASK)
        begin
            irq_mask <= I_REG_WDATA[1:0];
        end
    end

    assign O_IRQ = |(irq_status & irq_mask);

    // read data registered one cycle after the strobe; unmapped reads as zero
    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_RST)
        begin
            O_REG_RDATA <= 32'h0000_0000;
        end
        else if (I_CE)
        begin
            if (I_REG_RD)
            begin
                case (I_REG_ADDR)
                    `UFC_ADDR_PSW:       O_REG_RDATA <= O_PROCESSOR_STATUS_WORD;
                    `UFC_ADDR_IRQ_STAT:  O_REG_RDATA <= {30'h0000_0000, irq_status};
                    `UFC_ADDR_IRQ_MASK:  O_REG_RDATA <= {30'h0000_0000, irq_mask};
                    `UFC_ADDR_PIPE_STAT: O_REG_RDATA <= {29'h0000_0000, O_WB_VALID, s2_valid, s1_valid};
                    default:             O_REG_RDATA <= 32'h0000_0000;
                endcase
            end
            else
            begin
                O_REG_RDATA <= 32'h0000_0000;
            end
        end
    end

    // checks
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RST || !I_CE);

    sequence guarded_issue;
        accept && guard_true;
    endsequence

    result_latency_a: assert property (guarded_issue |=> I_CE [*2] ##1 O_WB_VALID)
        else $error("result not written three cycles after issue");
    false_guard_a: assert property (accept && !guard_true ##1 I_CE [*2] |=> !O_WB_VALID)
        else $error("false guard wrote the destination");
    bad_slot_a: assert property (I_ISSUE_VALID && !slot_ok |=> !s1_valid)
        else $error("issue in an illegal slot entered the pipe");
    flush_probe_a: assert property (accept && guard_true && issue_op == ufc_pkg::UFC_OP_FIX_TRUNC_FLAGS
        && I_SOURCE_OPERAND[30:23] == 8'h00 && I_SOURCE_OPERAND[22:0] != 23'h00_0000
        |=> I_CE [*2] ##1 O_WB_DATA == 32'h0000_0020)
        else $error("denormal probe did not report flushed input");
    probe_layout_a: assert property (O_WB_VALID && $past(s2_probe) |-> O_WB_DATA[31:6] == 26'h000_0000
        && O_WB_DATA[3:2] == 2'h0 && O_WB_DATA[0] == 1'b0)
        else $error("probe vector has bits outside the flag layout");
    probe_quiet_a: assert property (s2_valid && s2_probe && !psw_write && I_OTHER_FLAGS == '0
        |=> psw_flags == $past(psw_flags))
        else $error("probe changed the status flags");
    flags_sticky_a: assert property (!psw_write |=> (psw_flags & $past(psw_flags)) == $past(psw_flags))
        else $error("status flag fell without a status write");
    flags_with_wb_a: assert property (s2_valid && !s2_probe
        |=> O_WB_VALID && (psw_flags & $past(s2_flags)) == $past(s2_flags))
        else $error("conversion flags not set with the write-back");
    other_merge_a: assert property (1'b1 |=> (psw_flags & $past(I_OTHER_FLAGS)) == $past(I_OTHER_FLAGS))
        else $error("concurrent flag update lost");

    conv_cover_c:  cover property (accept && guard_true && issue_op == ufc_pkg::UFC_OP_UFLOAT ##3 O_WB_VALID);
    probe_cover_c: cover property (accept && guard_true && issue_op == ufc_pkg::UFC_OP_FIX_TRUNC_FLAGS
        ##3 O_WB_VALID);
    skip_cover_c:  cover property (accept && !guard_true);
    irq_cover_c:   cover property (O_IRQ);

endmodule // ufc_convert_unit

/* File: verilog/ufc_u2f_round.sv */
// unsigned integer to single precision converter with selectable rounding
`include "ufc_defs.svh"

module ufc_u2f_round
(
    input  wire logic [31:0]              i_value,  // unsigned source
    input  wire ufc_pkg::ufc_rmode_t      i_rmode,  // rounding mode
    output logic      [31:0]              o_result, // ieee single result
    output logic      [`UFC_FLAG_W-1:0]   o_flags   // raised exceptions
);

    // leading zero count of a nonzero word
    function automatic logic [4:0] lead_zeros(input logic [31:0] v);
        logic [4:0] n;
        n = 5'h00;
        for (int i = 0; i < 32; i++)
        begin
            if (v[i])
            begin
                n = 5'(31 - i);
            end
        end
        return n;
    endfunction

    logic [4:0]  lz;        // shift to normalise
    logic [31:0] norm;      // normalised value, bit 31 set
    logic        guard_bit; // first dropped bit
    logic        sticky;    // or of the rest
    logic        inexact;   // any bit dropped
    logic        incr;      // round up
    logic [7:0]  exp_raw;   // biased exponent before rounding

    // rounding up may carry into the exponent; adding over the packed
    // exponent and mantissa handles that without a special case
    always_comb
    begin
        lz        = lead_zeros(i_value);
        norm      = i_value << lz;
        guard_bit = norm[7];
        sticky    = |norm[6:0];
        inexact   = guard_bit | sticky;
        exp_raw   = 8'(8'h9E - {3'h0, lz});
        case (i_rmode)
            ufc_pkg::UFC_RM_NEAREST: incr = guard_bit & (sticky | norm[8]);
            ufc_pkg::UFC_RM_POS_INF: incr = inexact;
            default:                 incr = 1'b0;  // source is never negative
        endcase
        if (i_value == 32'h0000_0000)
        begin
            o_result = 32'h0000_0000;
            o_flags  = '0;
        end
        else
        begin
            o_result = {1'b0, 31'({exp_raw, norm[30:8]} + {30'h0000_0000, incr})};
            o_flags  = inexact ? `UFC_FLAG_INEXACT : '0;
        end
    end

endmodule // ufc_u2f_round
